// file: verilog/dtc_pkg.sv
// Constants and types of the tuning control port
// Functional notes
// - Strobe rising edge with enable captures byte
// - Strobe edges ignored while enable high
// - Four select lines pick destination register
// - Accumulator and output word advance each clock
// - Written values cross clock domains safely
// - Reset restores defaults, clears accumulator feedback
// - Reset acts only while transfer is low
// - Transfer copies all master registers at once
// - Transfer does not gate quadrant or gate pins
// - Quadrant select adds 0/90/180/270 phase
// - Gate high passes shift word to sum
// - Gate low feeds zero, register kept
// - Serial clock edge polarity is configurable
// - Addresses 0..5 hold base word bytes
// - Addresses 6..11 hold shift word bytes
// - Base top byte resets to 40h
package dtc_pkg;
  localparam int ACC_W = 48;
  localparam int OUT_W = 16;
  localparam logic [3:0] ADDR_BASE_LO = 4'h0;
  localparam logic [3:0] ADDR_BASE_HI = 4'h5;
  localparam logic [3:0] ADDR_SHIFT_LO = 4'h6;
  localparam logic [3:0] ADDR_SHIFT_HI = 4'hb;
  localparam logic [3:0] ADDR_SER_CTRL = 4'hc;
  localparam logic [7:0] BASE_HI_RESET = 8'h40;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] SER_CTRL_RESET = 8'h01;
  localparam int SER_CTRL_CLK_POL = 2;
  localparam int SER_CTRL_BASE_EN = 0;
  localparam int SER_W = 40;
  localparam int SER_SHIFT = 8;
  localparam int NUM_REGS = 13;
endpackage

// file: verilog/dtc_port.sv
// Tuning control port: host byte writes, transfer, phase accumulator
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dtc_port
  import dtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WR_CLK,
  input wire logic WE_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] DATA,
  input wire logic XFER_N,
  input wire logic RESET_N,
  input wire logic [1:0] QUADRANT_SELECT,
  input wire logic SHIFT_TERM_GATE,
  input wire logic SER_CLK,
  input wire logic SER_BIT_IN,
  output logic [ACC_W-1:0] PHASE,
  output logic [OUT_W-1:0] OUT_WORD
);
  // ----------------------------------------
  // Reset qualification
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic dev_reset;
  always_ff @(posedge CLOCK) begin
    rst_sync_reg <= {rst_sync_reg[0], ~(RESET_N | XFER_N)};
  end
  assign dev_reset = RST | rst_sync_reg[1];

  // Reset request carried into host domain through two strobe flops; masters clear only on strobe edges
  logic [1:0] wr_rst_reg;
  always_ff @(posedge WR_CLK) begin
    wr_rst_reg <= {wr_rst_reg[0], dev_reset};
  end

  // ----------------------------------------
  // Master registers, host strobe domain
  // ----------------------------------------
  logic [7:0] master_reg [NUM_REGS];
  logic wr_tog_reg;
  always_ff @(posedge WR_CLK) begin
    if (wr_rst_reg[1]) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        master_reg[i] <= BYTE_RESET;
      end
      master_reg[ADDR_BASE_HI] <= BASE_HI_RESET;
      master_reg[ADDR_SER_CTRL] <= SER_CTRL_RESET;
      wr_tog_reg <= 1'b0;
    end else if (!WE_N) begin
      if (ADDR <= ADDR_SER_CTRL) begin
        master_reg[ADDR] <= DATA;
      end
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // ----------------------------------------
  // Transfer request, synthesis domain
  // ----------------------------------------
  // Masters are only copied after the synced write toggle has held for one cycle,
  // so the word sampled is stable; host must not write while transfer is low
  logic [2:0] xfer_sync_reg;
  logic [2:0] tog_sync_reg;
  logic quiet;
  always_ff @(posedge CLOCK) begin
    xfer_sync_reg <= {xfer_sync_reg[1:0], ~XFER_N};
    tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
  end
  assign quiet = (tog_sync_reg[2] == tog_sync_reg[1]);

  logic [ACC_W-1:0] base_word_reg;
  logic [ACC_W-1:0] shift_word_reg;
  logic [7:0] ser_ctrl_reg;
  always_ff @(posedge CLOCK) begin
    if (dev_reset) begin
      base_word_reg <= {BASE_HI_RESET, 40'h0};
      shift_word_reg <= '0;
      ser_ctrl_reg <= SER_CTRL_RESET;
    end else if (xfer_sync_reg[2] && quiet) begin
      for (int b = 0; b < 6; b++) begin
        base_word_reg[8*b +: 8] <= master_reg[ADDR_BASE_LO + 4'(b)];
        shift_word_reg[8*b +: 8] <= master_reg[ADDR_SHIFT_LO + 4'(b)];
      end
      ser_ctrl_reg <= master_reg[ADDR_SER_CTRL];
    end
  end

  // ----------------------------------------
  // Serial term, serial clock domain
  // ----------------------------------------
  // Polarity bit is crossed as a level; changing it mid-frame is unsafe
  logic [1:0] pol_sync_reg;
  logic ser_clk_eff;
  logic [SER_W-1:0] ser_shift_reg;
  logic ser_tog_reg;
  always_ff @(posedge SER_CLK) begin
    pol_sync_reg <= {pol_sync_reg[0], ser_ctrl_reg[SER_CTRL_CLK_POL]};
  end
  assign ser_clk_eff = SER_CLK ^ pol_sync_reg[1];
  always_ff @(posedge ser_clk_eff) begin
    ser_shift_reg <= {ser_shift_reg[SER_W-2:0], SER_BIT_IN};
    ser_tog_reg <= ~ser_tog_reg;
  end

  // Serial word sampled only once its clock toggle has been quiet
  logic [2:0] ser_tog_sync_reg;
  logic [SER_W-1:0] ser_word_reg;
  always_ff @(posedge CLOCK) begin
    ser_tog_sync_reg <= {ser_tog_sync_reg[1:0], ser_tog_reg};
    if (dev_reset) begin
      ser_word_reg <= '0;
    end else if (ser_tog_sync_reg[2] == ser_tog_sync_reg[1]) begin
      ser_word_reg <= ser_shift_reg;
    end
  end

  // ----------------------------------------
  // Phase accumulator
  // ----------------------------------------
  // Modulation pins are asynchronous to the clock, so they pass two flops;
  // transfer never gates them, costing two cycles of modulation latency
  logic [1:0] quad_s1_reg;
  logic [1:0] quad_s2_reg;
  logic gate_s1_reg;
  logic gate_s2_reg;
  always_ff @(posedge CLOCK) begin
    quad_s1_reg <= QUADRANT_SELECT;
    quad_s2_reg <= quad_s1_reg;
    gate_s1_reg <= SHIFT_TERM_GATE;
    gate_s2_reg <= gate_s1_reg;
  end

  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] quad_off;
  assign step = (ser_ctrl_reg[SER_CTRL_BASE_EN] ? base_word_reg : '0)
              + (gate_s2_reg ? shift_word_reg : '0)
              + {ser_word_reg, 8'h00};
  assign quad_off = {quad_s2_reg, 46'h0};
  always_ff @(posedge CLOCK) begin
    if (dev_reset) begin
      acc_reg <= '0;
      PHASE <= '0;
      OUT_WORD <= '0;
    end else begin
      acc_reg <= acc_reg + step;
      PHASE <= acc_reg + quad_off;
      OUT_WORD <= OUT_W'((acc_reg + quad_off) >> (ACC_W - OUT_W));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_acc_step;
    @(posedge CLOCK) disable iff (dev_reset)
    !$past(dev_reset) |-> acc_reg == $past(acc_reg) + $past(step);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("Accumulator did not advance");
  property p_reset_clear;
    @(posedge CLOCK) $past(dev_reset) |-> acc_reg == '0 && base_word_reg[47:40] == BASE_HI_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset defaults wrong");
  property p_phase_quad;
    @(posedge CLOCK) disable iff (dev_reset)
    !$past(dev_reset) |-> PHASE[47:46] == 2'($past(acc_reg[47:46]) + $past(quad_s2_reg));
  endproperty
  a_phase_quad: assert property (p_phase_quad) else $error("Quadrant offset wrong");
  property p_hold_no_xfer;
    @(posedge CLOCK) disable iff (dev_reset)
    !xfer_sync_reg[2] |=> $stable(base_word_reg) && $stable(shift_word_reg);
  endproperty
  a_hold_no_xfer: assert property (p_hold_no_xfer) else $error("Active word changed without transfer");
  property p_out_top;
    @(posedge CLOCK) disable iff (dev_reset)
    OUT_WORD == PHASE[ACC_W-1 -: OUT_W];
  endproperty
  a_out_top: assert property (p_out_top) else $error("Output word not top of phase");
  property p_reset_rest;
    @(posedge CLOCK) $past(dev_reset) |-> shift_word_reg == '0 && ser_ctrl_reg == SER_CTRL_RESET;
  endproperty
  a_reset_rest: assert property (p_reset_rest) else $error("Shift or control default wrong");
endmodule // dtc_port
`default_nettype wire

// file: sim/dtc_host.sv
// Host processor model driving byte writes
`timescale 1ns/1ns
`default_nettype none
module dtc_host (
  output logic WR_CLK,
  output logic WE_N,
  output logic [3:0] ADDR,
  output logic [7:0] DATA
);
  // Strobe runs free: the master reset needs its edges
  initial begin
    WR_CLK = 1'b0;
    WE_N = 1'b1;
    ADDR = 4'hf;
    DATA = 8'h5a;
  end
  always begin
    #7 WR_CLK = 1'b1;
    #8 WR_CLK = 1'b0;
  end
  // Released bus shows inverted values, never a stale copy
  task put(input logic [3:0] a, input logic [7:0] d, input logic en);
    @(posedge WR_CLK);
    WE_N <= ~en;
    ADDR <= a;
    DATA <= d;
    @(posedge WR_CLK);
    WE_N <= 1'b1;
    ADDR <= ~a;
    DATA <= ~d;
  endtask
endmodule // dtc_host
`default_nettype wire

// file: sim/tb_dtc_port.sv
// Bench for the tuning control port
`timescale 1ns/1ns
`default_nettype none
module tb_dtc_port;
  import dtc_pkg::*;
  localparam logic [47:0] W1 = 48'h0123_4567_89ab;
  localparam logic [47:0] W2 = 48'hff00_0000_0011;
  localparam logic [47:0] WD = 48'h4000_0000_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xfer_n = 1'b0;
  logic res_n = 1'b0;
  logic [1:0] quad = 2'h0;
  logic gate = 1'b0;
  logic wr_clk, we_n;
  logic [3:0] addr;
  logic [7:0] data;
  logic [47:0] phase, p0, d;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  dtc_host host_u (.WR_CLK(wr_clk), .WE_N(we_n), .ADDR(addr), .DATA(data));
  dtc_port dut_u (.CLOCK(clk), .RST(rst), .WR_CLK(wr_clk), .WE_N(we_n), .ADDR(addr), .DATA(data),
    .XFER_N(xfer_n), .RESET_N(res_n), .QUADRANT_SELECT(quad), .SHIFT_TERM_GATE(gate),
    .SER_CLK(1'b0), .SER_BIT_IN(1'b0), .PHASE(phase), .OUT_WORD());
  task chk(input string what, input logic [47:0] exp);
    samples_checked++;
    if (d !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, d);
    end
  endtask
  // Advance over k cycles, sampled clear of the edge
  task meas(input int k);
    @(posedge clk);
    #1 p0 = phase;
    repeat (k) @(posedge clk);
    #1 d = phase - p0;
  endtask
  task load(input logic [3:0] a0, input logic [47:0] w);
    for (int i = 0; i < 6; i++) host_u.put(a0 + 4'(i), w[8*i+:8], 1'b1);
  endtask
  // Transfer waits out the write toggle window first
  task xfer;
    repeat (6) @(posedge clk);
    xfer_n <= 1'b0;
    repeat (4) @(posedge clk);
    xfer_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task t_base;
    load(ADDR_BASE_LO, W1);
    host_u.put(ADDR_BASE_LO, 8'hff, 1'b0);
    repeat (6) @(posedge clk);
    meas(1);
    chk("held step", WD);
    xfer;
    meas(1);
    chk("base step", W1);
    $display("base test done");
  endtask
  task t_shift;
    load(ADDR_SHIFT_LO, W2);
    xfer;
    meas(1);
    chk("gate low", W1);
    gate <= 1'b1;
    repeat (4) @(posedge clk);
    meas(1);
    chk("gate high", W1 + W2);
    gate <= 1'b0;
    repeat (4) @(posedge clk);
    meas(1);
    chk("gate kept", W1);
    $display("shift test done");
  endtask
  task t_quad;
    for (int q = 1; q < 4; q++) begin
      @(posedge clk);
      #1 p0 = phase;
      @(posedge clk) quad <= 2'(q);
      repeat (7) @(posedge clk);
      #1 d = phase - p0;
      chk("quadrant", 48'(8 * W1) + {2'(q), 46'h0});
      @(posedge clk) quad <= 2'h0;
      repeat (4) @(posedge clk);
    end
    $display("quadrant test done");
  endtask
  task t_rst;
    res_n <= 1'b0;
    repeat (6) @(posedge clk);
    res_n <= 1'b1;
    meas(1);
    chk("reset gated", W1);
    res_n <= 1'b0;
    xfer_n <= 1'b0;
    repeat (8) @(posedge clk);
    res_n <= 1'b1;
    xfer_n <= 1'b1;
    repeat (6) @(posedge clk);
    meas(1);
    chk("reset step", WD);
    $display("reset test done");
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    res_n <= 1'b1;
    xfer_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_base;
    t_shift;
    t_quad;
    t_rst;
    conclude;
  end
endmodule // tb_dtc_port
`default_nettype wire
